/* rtl/sdc_control.sv */
// Sequencing, pulsed supply and output decode of the sampled dual comparator
`timescale 1ns/100ps
`default_nettype none

// Function
// [RULE1] Channel result high when weighted input sum positive, low when negative.
// [RULE2] Pulsed supply driven high while active, released otherwise.
// [RULE3] Each comparison stays active, supply driven, for 80 microseconds.
// [RULE4] Outside inputs settle within 4 microseconds and hold through active period.
// [RULE5] Channel outputs follow own sign; both-low flag high only if both low.
// [RULE6] Window state low if A high, high if A low B high, else holds.
// [RULE7] External strobing: timing pin tied low, positive strobe pulse per comparison.
// [RULE8] Strobe rising edge starts a comparison; 50 ns pulses suffice.
// [RULE9] Strobe pulses may be shorter or longer than the active period.
// [RULE10] Self-timed: strobe held low, timing network restarts cycles repeatedly.
// [RULE11] Outputs hold while inactive and update only when a cycle completes.
module sdc_control
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                strobe,
  input  wire logic                rc_timing_pin,
  input  wire sdc_pkg::sdc_sign_s  signIn,
  output logic                     pulsedSupplyOut,
  output logic                     pulsedSupplyOe,
  output logic                     comparatorActive,
  output sdc_pkg::sdc_result_s     result
);
  import sdc_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] strobeSync_reg;
  logic [1:0] strobeSync_next;
  logic [1:0] rcSync_reg;
  logic [1:0] rcSync_next;
  logic       strobeLast_reg;
  logic       strobeLast_next;
  logic       rcLast_reg;
  logic       rcLast_next;
  sdc_sign_s  signSync1_reg;
  sdc_sign_s  signSync1_next;
  sdc_sign_s  signSync2_reg;
  sdc_sign_s  signSync2_next;
  logic       startPulse;

  // Two stages on each pin; edge detectors look at stage two only
  always_comb
  begin
    strobeSync_next = {strobeSync_reg[0], strobe};
    rcSync_next     = {rcSync_reg[0], rc_timing_pin};
    strobeLast_next = strobeSync_reg[1];
    rcLast_next     = rcSync_reg[1];
    signSync1_next  = signIn;
    signSync2_next  = signSync1_reg;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      strobeSync_reg <= 2'h0;
      rcSync_reg     <= 2'h0;
      strobeLast_reg <= 1'b0;
      rcLast_reg     <= 1'b0;
      signSync1_reg  <= '0;
      signSync2_reg  <= '0;
    end
    else
    begin
      strobeSync_reg <= strobeSync_next;
      rcSync_reg     <= rcSync_next;
      strobeLast_reg <= strobeLast_next;
      rcLast_reg     <= rcLast_next;
      signSync1_reg  <= signSync1_next;
      signSync2_reg  <= signSync2_next;
    end
  end

  // Either rising edge starts a cycle; the unused source is tied low outside
  assign startPulse = (strobeSync_reg[1] & ~strobeLast_reg)  // [RULE8] [RULE7]
                    | (rcSync_reg[1] & ~rcLast_reg);         // [RULE10]

  // ----------------------------------------------------------------------
  // Active-period sequencer
  // ----------------------------------------------------------------------
  sdc_state_e       state_reg;
  sdc_state_e       state_next;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             done;

  // Edges during an active period are ignored: a cycle cannot be cut short
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    done       = 1'b0;
    case (state_reg)
      SDC_IDLE:
      begin
        if (startPulse)
        begin
          state_next = SDC_ACTIVE;
          count_next = CNT_W'(ACTIVE_CYCLES - 1);  // [RULE3]
        end
      end
      SDC_ACTIVE:
      begin
        if (count_reg == CNT_ZERO)
        begin
          state_next = SDC_IDLE;
          done       = 1'b1;
        end
        else
        begin
          count_next = count_reg - CNT_ONE;
        end
      end
      default:
      begin
        state_next = SDC_IDLE;
        count_next = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= SDC_IDLE;
      count_reg <= CNT_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pulsed supply and result decode
  // ----------------------------------------------------------------------
  logic        supplyOn_reg;
  logic        supplyOn_next;
  sdc_result_s result_reg;
  sdc_result_s result_next;

  // Results sampled at the end of the period, after inputs have long settled
  always_comb
  begin
    supplyOn_next = (state_next == SDC_ACTIVE);  // [RULE2] [RULE3]
    result_next   = result_reg;
    if (done)                                    // [RULE11] [RULE4]
    begin
      result_next.chanAOut = signSync2_reg.chanAPositive;  // [RULE1] [RULE5]
      result_next.chanBOut = signSync2_reg.chanBPositive;  // [RULE1] [RULE5]
      result_next.bothLow  = ~signSync2_reg.chanAPositive
                           & ~signSync2_reg.chanBPositive; // [RULE5]
      if (signSync2_reg.chanAPositive)
        result_next.windowState = 1'b0;                    // [RULE6]
      else if (signSync2_reg.chanBPositive)
        result_next.windowState = 1'b1;                    // [RULE6]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      supplyOn_reg <= 1'b0;
      result_reg   <= '{RESULT_RST, RESULT_RST, BOTHLOW_RST, WINDOW_RST};
    end
    else
    begin
      supplyOn_reg <= supplyOn_next;
      result_reg   <= result_next;
    end
  end

  // Pin driven high only while enabled; released (high impedance) otherwise
  assign pulsedSupplyOut  = supplyOn_reg;  // [RULE2]
  assign pulsedSupplyOe   = supplyOn_reg;  // [RULE2]
  assign comparatorActive = supplyOn_reg;
  assign result           = result_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] onLen_reg;
  logic [CNT_W-1:0] onLen_next;

  // Length of the current high stretch; the counter keeps the checks free of long repetitions
  always_comb
  begin
    onLen_next = CNT_ZERO;
    if (supplyOn_reg)
      onLen_next = onLen_reg + CNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      onLen_reg <= CNT_ZERO;
    else
      onLen_reg <= onLen_next;
  end

  sequence s_start;
    !supplyOn_reg ##1 supplyOn_reg;
  endsequence

  property p_supply_oe;
    @(posedge clk_sys) disable iff (rst)
      (pulsedSupplyOe == (state_reg == SDC_ACTIVE)) && (pulsedSupplyOut == pulsedSupplyOe);
  endproperty
  a_supply_oe: assert property (p_supply_oe) else $error("supply enable and level differ"); // [RULE2]

  property p_on_len;
    @(posedge clk_sys) disable iff (rst)
      ($fell(supplyOn_reg)) |-> (onLen_reg == CNT_W'(ACTIVE_CYCLES));
  endproperty
  a_on_len: assert property (p_on_len) else $error("active period length wrong"); // [RULE3]

  property p_on_max;
    @(posedge clk_sys) disable iff (rst) onLen_reg <= CNT_W'(ACTIVE_CYCLES);
  endproperty
  a_on_max: assert property (p_on_max) else $error("active period overran"); // [RULE3]

  property p_start;
    @(posedge clk_sys) disable iff (rst)
      (startPulse && state_reg == SDC_IDLE) |-> s_start;
  endproperty
  a_start: assert property (p_start) else $error("edge did not start a cycle"); // [RULE8]

  property p_both_low;
    @(posedge clk_sys) disable iff (rst)
      result.bothLow == (!result.chanAOut && !result.chanBOut);
  endproperty
  a_both_low: assert property (p_both_low) else $error("both-low flag wrong"); // [RULE5]

  property p_window;
    @(posedge clk_sys) disable iff (rst)
      $changed(result) |-> (result.chanAOut ? !result.windowState
                          : (result.chanBOut ? result.windowState
                                             : result.windowState == $past(result.windowState)));
  endproperty
  a_window: assert property (p_window) else $error("window state decode wrong"); // [RULE6]

  property p_hold;
    @(posedge clk_sys) disable iff (rst)
      supplyOn_reg |-> $stable(result);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved during active period"); // [RULE11]

  property p_update;
    @(posedge clk_sys) disable iff (rst)
      $fell(supplyOn_reg) |-> (result.chanAOut == $past(signSync2_reg.chanAPositive)
                           && result.chanBOut == $past(signSync2_reg.chanBPositive));
  endproperty
  a_update: assert property (p_update) else $error("result not taken at cycle end"); // [RULE1]

endmodule : sdc_control

`default_nettype wire

/* rtl/sdc_pkg.sv */
// Package of constants and carrier types for the sampled dual comparator control
package sdc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int ACTIVE_TIME_NS  = 80000;
  localparam int SETTLE_TIME_NS  = 4000;
  localparam int ACTIVE_CYCLES   = ACTIVE_TIME_NS / CLK_PERIOD_NS;
  localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 14;
  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 14'h0001;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic RESULT_RST = 1'b0;
  localparam logic WINDOW_RST = 1'b0;
  // Both-low starts high so the reset set agrees with A and B low
  localparam logic BOTHLOW_RST = 1'b1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SDC_IDLE   = 2'b01,
    SDC_ACTIVE = 2'b10
  } sdc_state_e;

  // Sign of each channel's weighted input sum, from the analog front end
  typedef struct packed {
    logic chanAPositive;
    logic chanBPositive;
  } sdc_sign_s;

  // Decoded result set
  typedef struct packed {
    logic chanAOut;
    logic chanBOut;
    logic bothLow;
    logic windowState;
  } sdc_result_s;

endpackage : sdc_pkg

/* dv/sdc_sense_net.sv */
// Sensing network model powered by the pulsed supply
`timescale 1ns/100ps
`default_nettype none
module sdc_sense_net
(
  input  wire logic               clk_sys,
  input  wire logic               supplyLevel,
  input  wire sdc_pkg::sdc_sign_s wantSign,
  output sdc_pkg::sdc_sign_s      signOut
);
  import sdc_pkg::*;
  sdc_sign_s lastSign = 2'h1;
  // Unpowered network floats, so it shows a toggling pattern
  always_ff @(posedge clk_sys)
  begin
    lastSign <= (supplyLevel === 1'b1) ? wantSign : ~lastSign;
  end
  // Settles at once and holds while powered
  assign signOut = (supplyLevel === 1'b1) ? wantSign : lastSign;
endmodule : sdc_sense_net
`default_nettype wire

/* dv/sampled_dual_comparator_control_bench.sv */
// Self-checking bench of the sampled dual comparator control
`timescale 1ns/100ps
`default_nettype none
module sampled_dual_comparator_control_bench;
  import sdc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        strobe = 1'b0;
  logic        rcPin = 1'b0;
  logic        supOut;
  logic        supOe;
  logic        active;
  wire logic   supplyLevel;
  sdc_sign_s   wantSign = 2'h0;
  sdc_sign_s   signIn;
  sdc_result_s result;
  logic        expWin = 1'b0;
  int          fails = 0;
  int          samplesChecked = 0;

  always #5 clk_sys = ~clk_sys;
  // Pin level as the outside world sees it
  assign supplyLevel = supOe ? supOut : 1'bz;

  sdc_control dut_u (.clk_sys(clk_sys), .rst(rst), .strobe(strobe), .rc_timing_pin(rcPin),
    .signIn(signIn), .pulsedSupplyOut(supOut), .pulsedSupplyOe(supOe),
    .comparatorActive(active), .result(result));
  sdc_sense_net net_u (.clk_sys(clk_sys), .supplyLevel(supplyLevel), .wantSign(wantSign),
    .signOut(signIn));

  // ----
  // Shared tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Inputs move 1 ns after the edge, never on it
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  task automatic final_report();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // One comparison; the unused start pin stays low
  task automatic run_cycle(input sdc_sign_s s, input logic useRc, input logic shortPulse,
                           input logic retrig);
    int n;
    int m;
    logic held;
    sdc_result_s priorResult;
    wantSign = s;
    priorResult = result;
    held = 1'b1;
    n = 0;
    m = 0;
    if (useRc)
      rcPin = 1'b1;
    else
      strobe = 1'b1;
    while (active !== 1'b1 && n < 20)
    begin
      step();
      n++;
    end
    check("start latency", n, 3);
    if (n >= 20)
      final_report();
    // Short pulse is 40 ns; retrig edge lands mid-period and must be ignored
    while (active === 1'b1 && m < 9000)
    begin
      held &= (result === priorResult) && (supplyLevel === 1'b1);
      if (shortPulse && m == 1)
        strobe = 1'b0;
      if (retrig && m == 100)
        strobe = 1'b0;
      if (retrig && m == 110)
        strobe = 1'b1;
      step();
      m++;
    end
    check("held while active", held, 1);
    check("active cycles", m, ACTIVE_CYCLES);
    if (m >= 9000)
      final_report();
    check("supply released", supOe, 0);
    if (s.chanAPositive)
      expWin = 1'b0;
    else if (s.chanBPositive)
      expWin = 1'b1;
    check("result", result, {s.chanAPositive, s.chanBPositive,
      !s.chanAPositive && !s.chanBPositive, expWin});
    // Long pulse falls only after the period
    strobe = 1'b0;
    rcPin = 1'b0;
    repeat (20) step();
    check("no restart", active, 0);
  endtask : run_cycle

  // ----
  // Scenarios
  // ----
  task automatic test_reset();
    check("reset supply", {supOut, supOe, active}, 0);
    check("reset result", result, 4'h2);
    $display("test reset done");
  endtask : test_reset

  // Every sign pair, both-low twice so the window hold is seen at 1 and 0
  task automatic test_table();
    sdc_sign_s tbl[5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
    foreach (tbl[i])
      run_cycle(tbl[i], 1'b0, 1'b1, 1'b0);
    $display("test table done");
  endtask : test_table

  task automatic test_retrigger();
    run_cycle(2'h3, 1'b0, 1'b0, 1'b1);
    $display("test retrigger done");
  endtask : test_retrigger

  // Reset in mid-period drops the supply and restores the reset result set
  task automatic test_mid_reset();
    wantSign = 2'h2;
    strobe = 1'b1;
    repeat (10) step();
    check("mid active", active, 1);
    rst = 1'b1;
    repeat (3) step();
    check("mid reset supply", {supOut, supOe, active}, 0);
    check("mid reset result", result, 4'h2);
    rst = 1'b0;
    strobe = 1'b0;
    expWin = 1'b0;
    repeat (20) step();
    check("no start after reset", active, 0);
    $display("test mid reset done");
  endtask : test_mid_reset

  // Timing pin starts two cycles, each followed by 20 idle cycles
  task automatic test_self_timed();
    run_cycle(2'h1, 1'b1, 1'b0, 1'b0);
    run_cycle(2'h2, 1'b1, 1'b0, 1'b0);
    $display("test self timed done");
  endtask : test_self_timed

  initial
  begin
    repeat (20) step();
    test_reset();
    rst = 1'b0;
    step();
    test_table();
    test_retrigger();
    test_mid_reset();
    test_self_timed();
    final_report();
  end
endmodule : sampled_dual_comparator_control_bench
`default_nettype wire
